// >>> verilog/smsp_core.sv
// serial master/slave port with receive fifo and double-buffered read data
// assumes software-side ports on i_sys_clk; serial pins asynchronous, synchronised here
`timescale 1ns/1ps

// =====================================================================
// fifo
module smsp_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 4
) (
    input  wire logic             i_sys_clk,
    input  wire logic             i_rst_n,
    input  wire logic             i_in_valid,
    output logic                  o_in_ready,
    input  wire logic [WIDTH-1:0] i_in_data,
    output logic                  o_out_valid,
    input  wire logic             i_out_ready,
    output logic      [WIDTH-1:0] o_out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    wire              do_wr = i_in_valid && o_in_ready;
    wire              do_rd = o_out_valid && i_out_ready;

    assign o_in_ready  = (count != (AW+1)'(DEPTH));
    assign o_out_valid = (count != '0);
    assign o_out_data  = mem[rd_ptr];

    always_ff @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end
        else
        begin
            if (do_wr)
                wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
            if (do_rd)
                rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
            count <= count + (AW+1)'(do_wr) - (AW+1)'(do_rd);
        end
    end

    always_ff @(posedge i_sys_clk)
    begin
        if (do_wr)
            mem[wr_ptr] <= i_in_data;
    end
endmodule : smsp_fifo

// =====================================================================
// port core
// Notes on behaviour
// - nothing happens until module_on is set
// - master clock at most half system clock; slave at most a quarter
// - each completed character copied into the read buffer
// - data writes load shift register; reads return receive buffer
// - master drives mosi and clock; slave drives miso only when selected
// - clock_idle_level sets idle level and active edge of shift clock
// - sample_edge_select 1 samples on inactive edge, 0 on active edge
// - select_polarity chooses select active level, 0 low, 1 high
// - characters are 8 or 16 bits by char_length_sel
// - 8-bit characters use the low byte, right-justified
// - master clock is system clock over two times (divider plus one)
// - power-management request ignored while transfer_active
// - in power mode with switchback, master write or slave select triggers switchback
// - all port clocks stop in stop mode
// - master with fault detect sees asserted select as mode fault
// - mode fault clears controller_mode and module_on, sets fault_flag
// - fault_flag sticky; software setting it also requests interrupt
// - without fault detect select only blocks setting controller_mode
// - completion with receive fifo full overwrites read data and sets overrun_flag
// - write during transfer discarded, sets collision_flag in both modes
// - master write starts transfer, msb first out, lsb end in
// - transfer_active during transfer; at end buffer load and done_flag
// - slave select loss mid-character aborts without load or done
// - irq_enable_all gates fault, collision, overrun, done interrupts
module smsp_core #(
    parameter int DEPTH = smsp_pkg::FIFO_DEPTH
) (
    input  wire logic                i_sys_clk,
    input  wire logic                i_rst_n,
    input  wire logic                i_stop_mode,
    input  wire logic                i_module_on_set,
    input  wire logic                i_module_on_clr,
    input  wire logic                i_master_set,
    input  wire logic                i_master_clr,
    input  wire logic                i_fault_detect_on,
    input  wire smsp_pkg::smsp_cfg_s i_cfg,
    input  wire logic                i_data_wr,
    input  wire logic [15:0]         i_data_wdata,
    input  wire logic                i_data_rd,
    output logic      [15:0]         o_data_rdata,
    output logic                     o_rx_valid,
    input  wire smsp_pkg::smsp_clr_s i_flag_clr,
    input  wire logic                i_fault_flag_set,
    input  wire logic                i_pm_request,
    input  wire logic                i_pm_exit,
    input  wire logic                i_switchback_enable,
    output logic                     o_power_manage_mode,
    output logic                     o_switchback,
    output smsp_pkg::smsp_stat_s     o_stat,
    output logic                     o_module_on,
    output logic                     o_controller_mode,
    output logic                     o_irq,
    output logic                     o_sck_out,
    output logic                     o_sck_oe,
    input  wire logic                i_sck_in,
    output logic                     o_mosi_out,
    output logic                     o_mosi_oe,
    input  wire logic                i_mosi_in,
    output logic                     o_miso_out,
    output logic                     o_miso_oe,
    input  wire logic                i_miso_in,
    input  wire logic                i_select_in
);
    typedef enum logic [1:0] {ST_IDLE, ST_LEAD, ST_TRAIL} smsp_state_e;

    // =================================================================
    // pin synchronisers (primed flag, sck, mosi, miso, select)
    logic [4:0] sync1;
    logic [4:0] sync2;
    always_ff @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            sync1 <= 5'h00;
            sync2 <= 5'h00;
        end
        else if (!i_stop_mode)
        begin
            sync1 <= {1'b1, i_sck_in, i_mosi_in, i_miso_in, i_select_in};
            sync2 <= sync1;
        end
    end
    wire s_sck  = sync2[3];
    wire s_mosi = sync2[2];
    wire s_miso = sync2[1];
    wire s_sel  = sync2[0];

    // =================================================================
    // state
    logic        module_on;
    logic        master;
    smsp_state_e state;
    logic [7:0]  div_cnt;
    logic [4:0]  bit_cnt;
    logic [15:0] shreg;
    logic        sck_q;
    logic        sck_prev;
    logic [15:0] rxsh;
    logic [1:0]  smp_d, fin_d;
    logic        pmm;
    logic        done_flag;
    logic        overrun_flag;
    logic        collision_flag;
    logic        fault_flag;
    logic        prev_sel_act;

    wire        run        = module_on && !i_stop_mode;
    wire        sel_act    = sync2[4] && (s_sel ^ !i_cfg.select_polarity);
    wire        busy       = (state != ST_IDLE) || (fin_d != 2'h0);
    wire [4:0]  nbits      = i_cfg.char_length_sel ? smsp_pkg::BITS_16 : smsp_pkg::BITS_8;
    wire        msb_out    = i_cfg.char_length_sel ? shreg[15] : shreg[7];
    wire        mode_fault = run && master && i_fault_detect_on && sel_act;
    wire        wr_ok      = i_data_wr && !busy && run;
    wire        collide    = i_data_wr && busy;
    wire        div_tick   = run && master && busy && (div_cnt == i_cfg.clock_divide_ratio);
    // slave clock edges after synchronising; leading edge leaves idle level
    wire        s_lead     = run && !master && sel_act && (s_sck != sck_prev)
                             && (s_sck != i_cfg.clock_idle_level);
    wire        s_trail    = run && !master && sel_act && (s_sck != sck_prev)
                             && (s_sck == i_cfg.clock_idle_level);
    wire        lead_ev    = master ? (div_tick && state == ST_LEAD) : s_lead;
    wire        trail_ev   = master ? (div_tick && state == ST_TRAIL) : s_trail;
    wire        sample_ev  = i_cfg.sample_edge_select ? trail_ev : lead_ev;
    wire        shift_ev   = i_cfg.sample_edge_select ? lead_ev : trail_ev;
    wire        in_bit     = master ? s_miso : s_mosi;
    wire        last_bit   = (bit_cnt == nbits - 5'h01);
    wire        finish     = busy && trail_ev && last_bit;
    wire        abort      = busy && !master && !sel_act;
    // master sees miso two clocks late through the synchroniser, so capture and completion wait
    wire        cap_ev     = master ? smp_d[1] : sample_ev;
    wire        complete   = run && (master ? fin_d[1] : finish);
    wire [15:0] rx_next    = cap_ev ? {rxsh[14:0], in_bit} : rxsh;
    wire [15:0] rx_word    = i_cfg.char_length_sel ? rx_next : {8'h00, rx_next[7:0]};
    wire        fifo_ready;
    wire        fifo_valid;
    wire [15:0] fifo_data;
    wire        pop        = i_data_rd && fifo_valid;
    wire        overrun    = complete && !fifo_ready;

    // =================================================================
    // control bits
    always_ff @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            module_on <= 1'b0;
            master    <= 1'b0;
        end
        else if (mode_fault)
        begin
            module_on <= 1'b0;
            master    <= 1'b0;
        end
        else
        begin
            module_on <= i_module_on_set | (module_on & !i_module_on_clr);
            master    <= (i_master_set & !sel_act) | (master & !i_master_clr);
        end
    end

    // =================================================================
    // shift engine
    always_ff @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            state    <= ST_IDLE;
            div_cnt  <= smsp_pkg::DIV_RST;
            bit_cnt  <= 5'h00;
            shreg    <= smsp_pkg::DATA_RST;
            sck_q    <= 1'b0;
            sck_prev <= 1'b0;
            rxsh     <= smsp_pkg::DATA_RST;
            {smp_d, fin_d} <= 4'h0;
        end
        else
        begin
            sck_prev <= s_sck;
            {smp_d, fin_d} <= run ? {smp_d[0], sample_ev && master, fin_d[0], finish && master} : 4'h0;
            if (wr_ok)
                shreg <= i_data_wdata;
            div_cnt <= (!run || !busy || div_tick) ? smsp_pkg::DIV_RST : div_cnt + 8'h01;
            if (!run || abort)
            begin
                state   <= ST_IDLE;
                bit_cnt <= 5'h00;
                sck_q   <= i_cfg.clock_idle_level;
            end
            else
            begin
                case (state)
                    ST_IDLE:
                    begin
                        sck_q   <= i_cfg.clock_idle_level;
                        bit_cnt <= 5'h00;
                        if ((wr_ok && master) || (!master && sel_act))
                            state <= ST_LEAD;
                    end
                    ST_LEAD:
                    begin
                        if (lead_ev)
                        begin
                            sck_q <= !i_cfg.clock_idle_level;
                            state <= ST_TRAIL;
                        end
                    end
                    ST_TRAIL:
                    begin
                        if (trail_ev)
                        begin
                            sck_q   <= i_cfg.clock_idle_level;
                            bit_cnt <= bit_cnt + 5'h01;
                            state   <= last_bit ? ST_IDLE : ST_LEAD;
                        end
                    end
                    default:
                        state <= ST_IDLE;
                endcase
                if (cap_ev)
                    rxsh <= rx_next;
                if (shift_ev && !(lead_ev && bit_cnt == 5'h00 && i_cfg.sample_edge_select))
                    shreg <= {shreg[14:0], 1'b0};
                if (complete)
                    shreg <= rx_word;
            end
        end
    end

    // =================================================================
    // receive buffer
    smsp_fifo #(
        .WIDTH (smsp_pkg::DATA_W),
        .DEPTH (DEPTH)
    ) u_rx_fifo (
        .i_sys_clk   (i_sys_clk),
        .i_rst_n     (i_rst_n),
        .i_in_valid  (complete && fifo_ready),
        .o_in_ready  (fifo_ready),
        .i_in_data   (rx_word),
        .o_out_valid (fifo_valid),
        .i_out_ready (i_data_rd),
        .o_out_data  (fifo_data)
    );

    always_ff @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            o_data_rdata <= smsp_pkg::DATA_RST;
        else if (pop)
            o_data_rdata <= fifo_data;
        else if (overrun)
            o_data_rdata <= rx_word;
    end

    // =================================================================
    // flags, set wins over clear
    always_ff @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            done_flag      <= 1'b0;
            overrun_flag   <= 1'b0;
            collision_flag <= 1'b0;
            fault_flag     <= 1'b0;
            pmm            <= 1'b0;
            prev_sel_act   <= 1'b0;
        end
        else
        begin
            prev_sel_act   <= sel_act;
            done_flag      <= complete | (done_flag & !i_flag_clr.done);
            overrun_flag   <= overrun | (overrun_flag & !i_flag_clr.overrun);
            collision_flag <= collide | (collision_flag & !i_flag_clr.collision);
            fault_flag     <= mode_fault | i_fault_flag_set | (fault_flag & !i_flag_clr.fault);
            if (i_pm_request && !busy)
                pmm <= 1'b1;
            else if (i_pm_exit || o_switchback)
                pmm <= 1'b0;
        end
    end

    // =================================================================
    // outputs
    wire sb_src = (master && i_data_wr) || (!master && sel_act && !prev_sel_act);
    assign o_switchback        = pmm && i_switchback_enable && run && sb_src;
    assign o_power_manage_mode = pmm;
    assign o_irq = i_cfg.irq_enable_all &&
                   (fault_flag | collision_flag | overrun_flag | done_flag);
    assign o_stat      = '{transfer_active: busy, done_flag: done_flag, overrun_flag: overrun_flag,
                           collision_flag: collision_flag, fault_flag: fault_flag};
    assign o_module_on       = module_on;
    assign o_controller_mode = master;
    assign o_rx_valid        = fifo_valid;
    assign o_sck_out   = run && master ? sck_q : i_cfg.clock_idle_level;
    assign o_sck_oe    = run && master;
    assign o_mosi_out  = run && master && busy && msb_out;
    assign o_mosi_oe   = run && master;
    assign o_miso_out  = run && !master && sel_act && msb_out;
    assign o_miso_oe   = run && !master && sel_act;

    // =================================================================
    // checks
    a_fault_clears_mode: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        mode_fault |=> !module_on && !master && fault_flag)
        else $error("mode fault did not disable port");
    a_collision_sets: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        collide |=> collision_flag)
        else $error("collision flag not set");
    a_collision_keep: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        collide && !shift_ev && !complete |=> $stable(shreg))
        else $error("collision disturbed transfer");
    a_done_on_finish: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        complete |=> done_flag && !busy)
        else $error("done flag missing after transfer");
    a_overrun_sets: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        overrun |=> overrun_flag && o_data_rdata == $past(rx_word))
        else $error("overrun not reported");
    a_off_quiet: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        !run |-> !o_mosi_oe && !o_miso_oe && !o_sck_oe)
        else $error("outputs driven while off");
    a_abort_no_done: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        abort && !finish && !done_flag && !i_fault_flag_set |=> !done_flag)
        else $error("abort set done flag");
    a_miso_select: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        o_miso_oe |-> !master && sel_act)
        else $error("miso driven while unselected");
    a_irq_gate: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        !i_cfg.irq_enable_all |-> !o_irq)
        else $error("interrupt not gated");
    a_pm_ignored: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        i_pm_request && busy && !pmm |=> !pmm)
        else $error("power mode entered while busy");
    c_master_xfer: cover property (@(posedge i_sys_clk) disable iff (!i_rst_n) finish && master);
    c_slave_xfer: cover property (@(posedge i_sys_clk) disable iff (!i_rst_n) finish && !master);
    c_slave_abort: cover property (@(posedge i_sys_clk) disable iff (!i_rst_n) abort);
    c_mode_fault: cover property (@(posedge i_sys_clk) disable iff (!i_rst_n) mode_fault);
endmodule : smsp_core

// >>> inc/smsp_pkg.sv
// package for the serial master/slave port: timing constants, config struct, fifo depth
// assumes a 100 MHz system clock
package smsp_pkg;
    localparam int          SYS_CLK_MHZ     = 100;
    localparam int          SYS_CLK_HZ      = SYS_CLK_MHZ * 1000000;
    localparam int          SLAVE_MIN_RATIO = 4;
    localparam int          SYNC_STAGES     = 2;
    localparam int          FIFO_DEPTH      = 4;
    localparam int          DATA_W          = 16;
    localparam logic [4:0]  BITS_8          = 5'h08;
    localparam logic [4:0]  BITS_16         = 5'h10;
    localparam logic [7:0]  DIV_RST         = 8'h00;
    localparam logic [15:0] DATA_RST        = 16'h0000;

    typedef struct packed {
        logic       irq_enable_all;
        logic       select_polarity;
        logic       char_length_sel;
        logic       sample_edge_select;
        logic       clock_idle_level;
        logic [7:0] clock_divide_ratio;
    } smsp_cfg_s;

    typedef struct packed {
        logic transfer_active;
        logic done_flag;
        logic overrun_flag;
        logic collision_flag;
        logic fault_flag;
    } smsp_stat_s;

    typedef struct packed {
        logic fault;
        logic collision;
        logic overrun;
        logic done;
    } smsp_clr_s;
endpackage : smsp_pkg

// >>> test/smsp_slave_model.sv
// behavioural serial slave that faces the port while the port is master
// assumes the bench resolves the clock and data wires; miso is pulled high while not selected
`timescale 1ns/1ps

// =====================================================================
// slave model
module smsp_slave_model (
    input  wire logic        i_sck,
    input  wire logic        i_mosi,
    input  wire logic        i_sel,
    input  wire logic        i_cpol,
    input  wire logic        i_cpha,
    input  wire logic [4:0]  i_bits,
    input  wire logic [15:0] i_tx,
    output logic      [15:0] o_rx,
    output logic             o_miso
);
    int n_smp;
    int n_shown;

    // edges only, so a select change alone never counts as a clock edge
    always @(i_sck or negedge i_sel)
    begin
        if (!i_sel)
        begin
            n_smp = 0;
            n_shown = 0;
        end
        else if (i_sck == ~(i_cpol ^ i_cpha))
        begin
            o_rx = {o_rx[14:0], i_mosi};
            n_smp++;
        end
        else
        begin
            n_shown = n_smp;
        end
    end

    // index wraps so select may stay asserted between characters
    assign o_miso = i_sel ? i_tx[i_bits - 1 - (n_shown % i_bits)] : 1'b1;
endmodule : smsp_slave_model

// >>> test/spi_master_slave_port_tb_top.sv
// self-checking bench: master formats, flags, receive fifo, mode fault, slave transfers
// assumes smsp_pkg, the port core and the slave model are compiled before it
`timescale 1ns/1ps

// =====================================================================
// bench top
module spi_master_slave_port_tb_top;
    logic                 clk, rst_n, mod_set, mod_clr, mst_set, fd_on, wr, rd, pm_req;
    logic                 tb_sck, tb_mosi, sel_pin, m_sel, rx_valid, pmm, mod_on, ctl_mode, irq;
    logic                 sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe, m_miso, prev_sck;
    logic [15:0]          wdata, m_tx, m_rx, rdata;
    logic [31:0]          seed;
    logic [7:0]           sgot;
    smsp_pkg::smsp_cfg_s  cfg;
    smsp_pkg::smsp_clr_s  clr;
    smsp_pkg::smsp_stat_s stat;
    int                   num_errors, n_compared, cyc, half, last_half;
    wire                  sck  = sck_oe ? sck_o : tb_sck;
    wire                  mosi = mosi_oe ? mosi_o : tb_mosi;
    wire                  miso = miso_oe ? miso_o : m_miso;

    smsp_core dut_u (.i_sys_clk(clk), .i_rst_n(rst_n), .i_stop_mode(1'b0), .i_module_on_set(mod_set),
        .i_module_on_clr(mod_clr), .i_master_set(mst_set), .i_master_clr(1'b0), .i_fault_detect_on(fd_on),
        .i_cfg(cfg), .i_data_wr(wr), .i_data_wdata(wdata), .i_data_rd(rd), .o_data_rdata(rdata),
        .o_rx_valid(rx_valid), .i_flag_clr(clr), .i_fault_flag_set(1'b0), .i_pm_request(pm_req),
        .i_pm_exit(1'b0), .i_switchback_enable(1'b1), .o_power_manage_mode(pmm), .o_switchback(),
        .o_stat(stat), .o_module_on(mod_on), .o_controller_mode(ctl_mode), .o_irq(irq), .o_sck_out(sck_o),
        .o_sck_oe(sck_oe), .i_sck_in(sck), .o_mosi_out(mosi_o), .o_mosi_oe(mosi_oe), .i_mosi_in(mosi),
        .o_miso_out(miso_o), .o_miso_oe(miso_oe), .i_miso_in(miso), .i_select_in(sel_pin));

    smsp_slave_model peer_u (.i_sck(sck), .i_mosi(mosi), .i_sel(m_sel), .i_cpol(cfg.clock_idle_level),
        .i_cpha(cfg.sample_edge_select), .i_bits(cfg.char_length_sel ? smsp_pkg::BITS_16 : smsp_pkg::BITS_8),
        .i_tx(m_tx), .o_rx(m_rx), .o_miso(m_miso));

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // half-period monitor and run ceiling, a few thousand cycles are expected
    always @(posedge clk)
    begin
        cyc++;
        if (sck_o !== prev_sck)
        begin
            last_half = half;
            half = 0;
        end
        half++;
        prev_sck = sck_o;
        if (cyc == 60000)
        begin
            num_errors++;
            complete_run();
        end
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction : xs

    function automatic logic [15:0] msk(input logic [15:0] v);
        return cfg.char_length_sel ? v : {8'h00, v[7:0]};
    endfunction : msk

    task automatic complete_run();
        if (num_errors == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : complete_run

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp)
        begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    task automatic pop();
        rd = 1'b1;
        tick(1);
        rd = 1'b0;
        tick(1);
    endtask : pop

    task automatic clear();
        clr = '1;
        tick(1);
        clr = '0;
    endtask : clear

    task automatic xfer(input logic [15:0] d, input logic [15:0] s, input logic do_pop, input logic col);
        int k;
        m_tx = s;
        wdata = d;
        wr = 1'b1;
        tick(1);
        wr = 1'b0;
        check("busy", 16'h0001, {15'h0000, stat.transfer_active});
        if (col)
        begin
            wdata = ~d;
            wr = 1'b1;
            pm_req = 1'b1;
            tick(1);
            {wr, pm_req} = 2'b00;
            check("pm mode", 16'h0000, {15'h0000, pmm});
        end
        k = 0;
        while (stat.transfer_active !== 1'b0 && k < 9000)
        begin
            tick(1);
            k++;
        end
        check("done", 16'h0001, {15'h0000, stat.done_flag});
        check("collision", {15'h0000, col}, {15'h0000, stat.collision_flag});
        check("mosi word", msk(d), msk(m_rx));
        check("half period", 16'(cfg.clock_divide_ratio) + 16'h0001, 16'(last_half));
        check("irq", {15'h0000, cfg.irq_enable_all}, {15'h0000, irq});
        if (do_pop)
        begin
            pop();
            check("rdata", msk(s), rdata);
        end
    endtask : xfer

    task automatic slv(input logic [7:0] d, input logic [7:0] m, input int nb);
        wdata = {m, d};
        wr = 1'b1;
        tick(1);
        wr = 1'b0;
        sel_pin = 1'b1;
        for (int i = 7; i > 7 - nb; i--)
        begin
            tb_mosi = m[i];
            tick(8);
            sgot[i] = miso;
            tb_sck = 1'b1;
            tick(8);
            tb_sck = 1'b0;
        end
        tick(8);
        sel_pin = 1'b0;
        tick(8);
    endtask : slv

    initial
    begin
        {mod_set, mod_clr, mst_set, fd_on, wr, rd, pm_req, tb_sck, tb_mosi, m_sel, prev_sck} = '0;
        {wdata, m_tx, cfg, clr, sgot} = '0;
        {num_errors, n_compared, cyc, half, last_half} = '0;
        sel_pin = 1'b1;
        seed = 32'h9283;
        rst_n = 1'b0;
        repeat (3) @(posedge clk);
        #1;
        rst_n = 1'b1;
        check("reset", 16'h0000, {8'h00, stat, sck_oe, mosi_oe, miso_oe});
        {mod_set, mst_set} = 2'b11;
        tick(1);
        {mod_set, mst_set} = 2'b00;
        for (int i = 0; i < 8; i++)
        begin
            seed = xs(seed);
            m_sel = 1'b0;
            {cfg.char_length_sel, cfg.sample_edge_select, cfg.clock_idle_level} = 3'(i);
            cfg.clock_divide_ratio = (i == 0) ? 8'h00 : {5'h00, seed[2:0]};
            cfg.irq_enable_all = seed[8];
            clear();
            tick(2);
            m_sel = 1'b1;
            check("idle level", {15'h0000, cfg.clock_idle_level}, {15'h0000, sck_o});
            xfer(seed[31:16], seed[15:0] ^ 16'hA5C3, 1'b1, i == 7);
        end
        clear();
        pm_req = 1'b1;
        tick(1);
        pm_req = 1'b0;
        check("pm entry", 16'h0001, {15'h0000, pmm});
        for (int i = 0; i < 5; i++)
        begin
            seed = xs(seed);
            xfer(seed[15:0], seed[31:16], 1'b0, 1'b0);
            check("overrun", {15'h0000, i == 4}, {15'h0000, stat.overrun_flag});
        end
        check("newest", msk(seed[31:16]), rdata);
        check("switchback", 16'h0000, {15'h0000, pmm});
        repeat (4) pop();
        check("drained", 16'h0000, {15'h0000, rx_valid});
        m_sel = 1'b0;
        mod_clr = 1'b1;
        tick(1);
        mod_clr = 1'b0;
        wr = 1'b1;
        tick(1);
        wr = 1'b0;
        tick(3);
        check("off", 16'h0000, {12'h000, mod_on, stat.transfer_active, sck_oe, mosi_oe});
        {cfg.select_polarity, cfg.irq_enable_all, sel_pin} = 3'b110;
        clear();
        tick(2);
        {mod_set, mst_set} = 2'b11;
        tick(1);
        {mod_set, mst_set} = 2'b00;
        sel_pin = 1'b1;
        tick(6);
        check("no fault", 16'h0003, {14'h0000, mod_on, ctl_mode});
        fd_on = 1'b1;
        tick(6);
        check("fault", 16'h0001, {13'h0000, mod_on, ctl_mode, stat.fault_flag});
        check("fault irq", 16'h0001, {15'h0000, irq});
        {fd_on, sel_pin} = 2'b00;
        tick(4);
        check("fault sticky", 16'h0001, {15'h0000, stat.fault_flag});
        clear();
        {cfg.char_length_sel, cfg.sample_edge_select, cfg.clock_idle_level} = 3'b000;
        mod_set = 1'b1;
        tick(1);
        mod_set = 1'b0;
        seed = xs(seed);
        slv(seed[7:0], seed[15:8], 3);
        check("abort", 16'h0000, {14'h0000, stat.done_flag, rx_valid});
        slv(seed[23:16], seed[31:24], 8);
        check("slave done", 16'h0003, {14'h0000, stat.done_flag, rx_valid});
        check("slave miso", {8'h00, seed[23:16]}, {8'h00, sgot});
        check("miso released", 16'h0000, {15'h0000, miso_oe});
        pop();
        check("slave rdata", {8'h00, seed[31:24]}, rdata);
        complete_run();
    end
endmodule : spi_master_slave_port_tb_top
